// ==== hw/mcr_top.sv ====
// command register group: resets, settings update, checksum, password, firmware
//
// Notes on behaviour
// RL1: correct password at initiate enters update mode
// RL2: any write to terminate resets the device
// RL3: calculate command sums working settings copy
// RL4: checksum word writable; write commits to EEPROM
// RL5: new password word always reads zero
// RL6: master sends passwords from 0 to 9999
// RL7: correct password at firmware word starts update
// RL8: reset commands clear only with correct password
// RL9: settings words writable only in update mode
// RL10: status reports 12 comm update, 10 buttons
`timescale 1ns/1ps
`include "mcr_params.svh"
module mcr_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire mcr_pkg::mcr_word_t reg_addr,
  input wire mcr_pkg::mcr_word_t reg_wdata,
  output mcr_pkg::mcr_word_t reg_rdata,
  output logic reg_rvalid,
  input wire logic button_update,
  output logic extreme_reset_pulse,
  output logic energy_reset_pulse,
  output logic self_reset_pulse,
  output logic eeprom_commit_pulse,
  output logic fw_update_start,
  output logic update_mode
);
  import mcr_pkg::*;

  mcr_cs_if cs_bus ();

  mcr_mode_t mode_r;
  mcr_word_t pwd_r;
  mcr_word_t csum_r;
  mcr_word_t fw_r;
  mcr_word_t rdata_r;
  mcr_word_t ps_mem_r [0:7];
  logic rvalid_r;
  logic cs_start_r;
  logic btn_s1_r;
  logic btn_s2_r;
  logic btn_s3_r;
  logic xrst_r;
  logic erst_r;
  logic srst_r;
  logic commit_r;
  logic fw_go_r;
  logic upd_r;
  logic btn_rise;
  logic wr_xrst;
  logic wr_erst;
  logic wr_init;
  logic wr_term;
  logic wr_calc;
  logic wr_csum;
  logic wr_npwd;
  logic wr_fwup;
  logic wr_ps;

  // password check: must match and lie in the decimal 0..9999 range
  function automatic logic pwd_ok(input mcr_word_t w, input mcr_word_t p);
    pwd_ok = (w == p) && (w <= `MCR_PWD_MAX);
  endfunction

  // settings window decode
  function automatic logic is_ps(input mcr_word_t a);
    is_ps = (a >= `MCR_OFS_PS_BASE) && (a < (`MCR_OFS_PS_BASE + `MCR_PS_WORDS));
  endfunction

  // offset of an address inside the settings window
  function automatic mcr_idx_t ps_idx(input mcr_word_t a);
    mcr_word_t d;
    d = a - `MCR_OFS_PS_BASE;
    ps_idx = d[2:0];
  endfunction

  // write decodes
  assign wr_xrst = reg_wr && (reg_addr == `MCR_OFS_XRST);
  assign wr_erst = reg_wr && (reg_addr == `MCR_OFS_ERST);
  assign wr_init = reg_wr && (reg_addr == `MCR_OFS_INIT);
  assign wr_term = reg_wr && (reg_addr == `MCR_OFS_TERM);
  assign wr_calc = reg_wr && (reg_addr == `MCR_OFS_CALC);
  assign wr_csum = reg_wr && (reg_addr == `MCR_OFS_CSUM);
  assign wr_npwd = reg_wr && (reg_addr == `MCR_OFS_NPWD);
  assign wr_fwup = reg_wr && (reg_addr == `MCR_OFS_FWUP);
  assign wr_ps = reg_wr && is_ps(reg_addr);
  assign btn_rise = btn_s2_r && !btn_s3_r;

  // front button crosses in from a pin: two flops, then edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
      btn_s3_r <= 1'b0;
    end else begin
      btn_s1_r <= button_update;
      btn_s2_r <= btn_s1_r;
      btn_s3_r <= btn_s2_r;
    end
  end

  // operating mode; terminate wins over any entry in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= MCR_RUN;
    end else begin
      case (mode_r)
        MCR_RUN: begin
          // RL1: password gated entry at initiate; button entry needs no password
          if (wr_term) begin
            mode_r <= MCR_RUN;
          end else if (wr_init && pwd_ok(reg_wdata, pwd_r)) begin
            mode_r <= MCR_UPD_COM;
          end else if (btn_rise) begin
            mode_r <= MCR_UPD_BTN;
          end
        end
        MCR_UPD_BTN, MCR_UPD_COM: begin
          // RL2: leave via reset
          if (wr_term) begin
            mode_r <= MCR_RUN;
          end
        end
        default: mode_r <= MCR_RUN;
      endcase
    end
  end

  // command pulses, each one cycle wide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xrst_r <= 1'b0;
      erst_r <= 1'b0;
      srst_r <= 1'b0;
      fw_go_r <= 1'b0;
    end else begin
      // RL8: wrong password has no effect
      xrst_r <= wr_xrst && pwd_ok(reg_wdata, pwd_r);
      erst_r <= wr_erst && pwd_ok(reg_wdata, pwd_r);
      // RL2: any value resets
      srst_r <= wr_term;
      // RL7: password gated firmware start
      fw_go_r <= wr_fwup && pwd_ok(reg_wdata, pwd_r);
    end
  end

  // firmware word keeps what was written so it reads back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fw_r <= 16'h0000;
    end else if (wr_fwup) begin
      fw_r <= reg_wdata;
    end
  end

  // password store; out-of-range values would never verify, so refuse them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwd_r <= `MCR_PWD_RST;
    end else if (wr_npwd && (reg_wdata <= `MCR_PWD_MAX)) begin
      pwd_r <= reg_wdata;
    end
  end

  // working copy of the settings words
  always_ff @(posedge clk) begin
    // RL9: locked outside update
    if (wr_ps && (mode_r != MCR_RUN)) begin
      ps_mem_r[ps_idx(reg_addr)] <= reg_wdata;
    end
  end

  // checksum start; a request while busy is dropped, not queued
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_start_r <= 1'b0;
    end else begin
      // RL3: kick the walker
      cs_start_r <= wr_calc && !cs_bus.busy && !cs_start_r;
    end
  end

  assign cs_bus.start = cs_start_r;
  assign cs_bus.word = ps_mem_r[cs_bus.idx];

  mcr_checksum u_checksum (
    .clk(clk),
    .rst(rst),
    .cs(cs_bus)
  );

  // checksum word: master write beats a finishing walk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csum_r <= `MCR_CSUM_RST;
      commit_r <= 1'b0;
    end else begin
      // RL4: write commits to EEPROM
      commit_r <= wr_csum;
      if (wr_csum) begin
        csum_r <= reg_wdata;
      end else if (cs_bus.done) begin
        csum_r <= cs_bus.sum;
      end
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      rdata_r <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `MCR_OFS_CSUM) begin
          rdata_r <= csum_r;
        end else if (reg_addr == `MCR_OFS_FWUP) begin
          rdata_r <= fw_r;
        end else if (reg_addr == `MCR_OFS_INIT) begin
          rdata_r <= (mode_r == MCR_RUN) ? 16'h0000 : `MCR_INIT_ACTIVE;
        end else if (reg_addr == `MCR_OFS_STAT) begin
          // RL10: state code field
          case (mode_r)
            MCR_UPD_COM: rdata_r <= {8'h00, `MCR_ST_COM};
            MCR_UPD_BTN: rdata_r <= {8'h00, `MCR_ST_BTN};
            default: rdata_r <= {8'h00, `MCR_ST_RUN};
          endcase
        end else if (is_ps(reg_addr)) begin
          rdata_r <= ps_mem_r[ps_idx(reg_addr)];
        end
        // RL5: password reads zero via default
      end
    end
  end

  // update flag mirrors the mode through its own flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= (mode_r != MCR_RUN) && !wr_term;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign extreme_reset_pulse = xrst_r;
  assign energy_reset_pulse = erst_r;
  assign self_reset_pulse = srst_r;
  assign eeprom_commit_pulse = commit_r;
  assign fw_update_start = fw_go_r;
  assign update_mode = upd_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_calc_req;
    wr_calc && !cs_bus.busy && !cs_start_r;
  endsequence
  // walk ends ten cycles after the accepted request; a master write in that cycle wins
  sequence s_calc_done;
    ##10 cs_bus.done ##1 ($past(wr_csum) || (csum_r == $past(cs_bus.sum)));
  endsequence

  property p_init_enter;
    (mode_r == MCR_RUN && wr_init && !wr_term && pwd_ok(reg_wdata, pwd_r))
      |=> (mode_r == MCR_UPD_COM) ##1 update_mode;
  endproperty
  a_init_enter: assert property (p_init_enter) else $error("good password did not enter update"); // RL1

  property p_init_bad;
    (mode_r == MCR_RUN && wr_init && !btn_rise && !pwd_ok(reg_wdata, pwd_r)) |=> mode_r == MCR_RUN;
  endproperty
  a_init_bad: assert property (p_init_bad) else $error("bad password entered update"); // RL1

  property p_term;
    wr_term |=> self_reset_pulse && (mode_r == MCR_RUN) && !update_mode;
  endproperty
  a_term: assert property (p_term) else $error("terminate did not reset"); // RL2

  property p_calc;
    s_calc_req |-> s_calc_done;
  endproperty
  a_calc: assert property (p_calc) else $error("checksum not stored after calculate"); // RL3

  property p_commit;
    wr_csum |=> eeprom_commit_pulse && (csum_r == $past(reg_wdata));
  endproperty
  a_commit: assert property (p_commit) else $error("checksum write did not commit"); // RL4

  property p_npwd_zero;
    (reg_rd && reg_addr == `MCR_OFS_NPWD) |=> reg_rvalid && (reg_rdata == 16'h0000);
  endproperty
  a_npwd_zero: assert property (p_npwd_zero) else $error("password word read nonzero"); // RL5

  property p_fw;
    wr_fwup |=> (fw_update_start == pwd_ok($past(reg_wdata), $past(pwd_r)));
  endproperty
  a_fw: assert property (p_fw) else $error("firmware start mismatch"); // RL7

  property p_xrst;
    wr_xrst |=> (extreme_reset_pulse == pwd_ok($past(reg_wdata), $past(pwd_r)));
  endproperty
  a_xrst: assert property (p_xrst) else $error("extreme reset gating wrong"); // RL8

  property p_ps_lock;
    (mode_r == MCR_RUN) |=> $stable(ps_mem_r[0]);
  endproperty
  a_ps_lock: assert property (p_ps_lock) else $error("settings changed outside update"); // RL9

  property p_status;
    (reg_rd && reg_addr == `MCR_OFS_STAT && mode_r == MCR_UPD_COM) |=> reg_rdata == 16'h000C;
  endproperty
  a_status: assert property (p_status) else $error("status code not 12"); // RL10
endmodule

// ==== hw/mcr_params.svh ====
// offsets, field values and sizes for the meter command register group
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH
`define MCR_OFS_XRST 16'h4E1F
`define MCR_OFS_ERST 16'h4E20
`define MCR_OFS_INIT 16'h55EF
`define MCR_OFS_TERM 16'h55F0
`define MCR_OFS_CALC 16'h55F1
`define MCR_OFS_CSUM 16'h55F2
`define MCR_OFS_NPWD 16'h55F3
`define MCR_OFS_FWUP 16'h59D7
`define MCR_OFS_STAT 16'h1387
`define MCR_OFS_PS_BASE 16'h752F
`define MCR_PS_WORDS 16'h0008
`define MCR_PS_LAST 3'h7
`define MCR_PWD_MAX 16'h270F
`define MCR_PWD_RST 16'h0000
`define MCR_CSUM_RST 16'h0000
`define MCR_ST_RUN 8'h01
`define MCR_ST_BTN 8'h0A
`define MCR_ST_COM 8'h0C
`define MCR_INIT_ACTIVE 16'h0001
`endif

// ==== hw/mcr_pkg.sv ====
// shared types of the meter command register group
package mcr_pkg;
  typedef logic [15:0] mcr_word_t;
  typedef logic [2:0] mcr_idx_t;
  typedef enum logic [2:0] {
    MCR_RUN = 3'b001,
    MCR_UPD_BTN = 3'b010,
    MCR_UPD_COM = 3'b100
  } mcr_mode_t;
  typedef enum logic [1:0] {
    MCR_CS_IDLE = 2'b01,
    MCR_CS_SUM = 2'b10
  } mcr_cs_state_t;
endpackage

// ==== hw/mcr_cs_if.sv ====
// link between command logic and the checksum walker
`timescale 1ns/1ps
interface mcr_cs_if;
  logic start;
  logic busy;
  logic done;
  mcr_pkg::mcr_word_t sum;
  mcr_pkg::mcr_idx_t idx;
  mcr_pkg::mcr_word_t word;
  modport calc(input start, input word, output busy, output done, output sum, output idx);
  modport host(output start, output word, input busy, input done, input sum, input idx);
endinterface

// ==== hw/mcr_checksum.sv ====
// sequential checksum over the working copy of the settings words
`timescale 1ns/1ps
`include "mcr_params.svh"
module mcr_checksum (
  input wire logic clk,
  input wire logic rst,
  mcr_cs_if.calc cs
);
  import mcr_pkg::*;

  mcr_cs_state_t state_r;
  mcr_idx_t idx_r;
  mcr_word_t acc_r;
  logic done_r;

  // walker state: one word per cycle, cheaper than a wide adder tree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= MCR_CS_IDLE;
    end else begin
      case (state_r)
        MCR_CS_IDLE: begin
          if (cs.start) begin
            state_r <= MCR_CS_SUM;
          end
        end
        MCR_CS_SUM: begin
          if (idx_r == `MCR_PS_LAST) begin
            state_r <= MCR_CS_IDLE;
          end
        end
        default: state_r <= MCR_CS_IDLE;
      endcase
    end
  end

  // word index and running sum
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 3'h0;
      acc_r <= 16'h0000;
    end else if (state_r == MCR_CS_IDLE && cs.start) begin
      idx_r <= 3'h0;
      acc_r <= 16'h0000;
    end else if (state_r == MCR_CS_SUM) begin
      idx_r <= idx_r + 3'h1;
      acc_r <= acc_r + cs.word;
    end
  end

  // completion pulse, sum is final in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == MCR_CS_SUM) && (idx_r == `MCR_PS_LAST);
    end
  end

  assign cs.busy = (state_r == MCR_CS_SUM);
  assign cs.done = done_r;
  assign cs.sum = acc_r;
  assign cs.idx = idx_r;

  // RL3: walk finishes
  property p_cs_finish;
    @(posedge clk) disable iff (rst)
      (state_r == MCR_CS_IDLE && cs.start) |-> ##9 done_r;
  endproperty
  a_cs_finish: assert property (p_cs_finish) else $error("checksum walk not done in 9 cycles"); // RL3
endmodule

// ==== test/mcr_master_model.sv ====
// remote register master model driving the command register group
`timescale 1ns/1ps
module mcr_master_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output mcr_pkg::mcr_word_t reg_addr,
  output mcr_pkg::mcr_word_t reg_wdata,
  input wire mcr_pkg::mcr_word_t reg_rdata,
  input wire logic reg_rvalid
);
  import mcr_pkg::*;

  // idle bus from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  function automatic mcr_word_t pwd(input int n);
    return mcr_word_t'(n % 10000);
  endfunction

  // one access; gap idle cycles first lets the master act slowly
  task automatic xfer(input logic rd, input mcr_word_t a, input mcr_word_t d, input int gap,
      output mcr_word_t q, output logic v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    reg_rd <= rd;
    reg_wr <= ~rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    // released lines show inverted values, so stale data cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ==== test/mcr_top_bench.sv ====
// self-checking bench for the command register group
`timescale 1ns/1ps
`include "mcr_params.svh"
module mcr_top_bench;
  import mcr_pkg::*;
  localparam logic [15:0] P_XR = 16'h0010;
  localparam logic [15:0] P_ER = 16'h0008;
  localparam logic [15:0] P_SR = 16'h0004;
  localparam logic [15:0] P_CM = 16'h0002;
  localparam logic [15:0] P_FW = 16'h0001;
  logic clk;
  logic rst;
  logic button_update;
  logic reg_wr;
  logic reg_rd;
  mcr_word_t reg_addr;
  mcr_word_t reg_wdata;
  mcr_word_t reg_rdata;
  logic reg_rvalid;
  logic extreme_reset_pulse;
  logic energy_reset_pulse;
  logic self_reset_pulse;
  logic eeprom_commit_pulse;
  logic fw_update_start;
  logic update_mode;
  logic [15:0] pulses;
  int n_mismatch;
  int compares;

  mcr_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .button_update(button_update), .extreme_reset_pulse(extreme_reset_pulse),
    .energy_reset_pulse(energy_reset_pulse), .self_reset_pulse(self_reset_pulse),
    .eeprom_commit_pulse(eeprom_commit_pulse), .fw_update_start(fw_update_start),
    .update_mode(update_mode));
  mcr_master_model u_mst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // all one-cycle strobes packed for a single compare
  assign pulses = {11'h000, extreme_reset_pulse, energy_reset_pulse, self_reset_pulse,
    eeprom_commit_pulse, fw_update_start};

  // 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // write, then look at the strobes in the one cycle they stand
  task automatic wr(input mcr_word_t a, input mcr_word_t d, input logic [15:0] exp_p);
    mcr_word_t q;
    logic v;
    // odd offsets come after an idle cycle, so both master paces are seen
    u_mst.xfer(1'b0, a, d, int'(a[0]), q, v);
    chk("strobes", exp_p, pulses);
  endtask

  task automatic rd(input mcr_word_t a, input mcr_word_t exp);
    mcr_word_t q;
    logic v;
    // data lines carry junk during a read; the read must not write anything
    u_mst.xfer(1'b1, a, a, 1, q, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk("rdata", exp, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_after_reset();
    idle(1);
    chk("update_mode", 16'h0000, {15'h0000, update_mode});
    rd(`MCR_OFS_STAT, 16'h0001);
    rd(`MCR_OFS_CSUM, `MCR_CSUM_RST);
    rd(`MCR_OFS_INIT, 16'h0000);
    rd(16'h0100, 16'h0000);
    $display("test after_reset done");
  endtask

  task automatic t_reset_cmds();
    wr(`MCR_OFS_XRST, u_mst.pwd(1), 16'h0000);
    wr(`MCR_OFS_XRST, `MCR_PWD_RST, P_XR);
    wr(`MCR_OFS_ERST, u_mst.pwd(9999), 16'h0000);
    wr(`MCR_OFS_ERST, `MCR_PWD_RST, P_ER);
    $display("test reset_cmds done");
  endtask

  task automatic t_settings();
    mcr_word_t sum;
    sum = 16'h0000;
    wr(`MCR_OFS_INIT, u_mst.pwd(5), 16'h0000);
    idle(1);
    chk("update_mode", 16'h0000, {15'h0000, update_mode});
    wr(`MCR_OFS_INIT, `MCR_PWD_RST, 16'h0000);
    idle(1);
    chk("update_mode", 16'h0001, {15'h0000, update_mode});
    rd(`MCR_OFS_STAT, 16'h000C);
    rd(`MCR_OFS_INIT, `MCR_INIT_ACTIVE);
    for (int i = 0; i < 8; i++) begin
      wr(`MCR_OFS_PS_BASE + 16'(i), 16'(i * 16'h1111 + 16'h0F01), 16'h0000);
      sum = sum + 16'(i * 16'h1111 + 16'h0F01);
    end
    wr(`MCR_OFS_TERM, 16'h1234, P_SR);
    idle(1);
    chk("update_mode", 16'h0000, {15'h0000, update_mode});
    rd(`MCR_OFS_STAT, 16'h0001);
    wr(`MCR_OFS_PS_BASE, 16'hDEAD, 16'h0000);
    rd(`MCR_OFS_PS_BASE, 16'h0F01);
    wr(`MCR_OFS_INIT, `MCR_PWD_RST, 16'h0000);
    wr(`MCR_OFS_CALC, 16'h0000, 16'h0000);
    idle(12);
    rd(`MCR_OFS_CSUM, sum);
    rd(`MCR_OFS_CALC, 16'h0000);
    $display("test settings done");
  endtask

  task automatic t_checksum_write();
    wr(`MCR_OFS_CSUM, 16'h2468, P_CM);
    rd(`MCR_OFS_CSUM, 16'h2468);
    wr(`MCR_OFS_TERM, 16'h0000, P_SR);
    $display("test checksum_write done");
  endtask

  task automatic t_password();
    wr(`MCR_OFS_NPWD, u_mst.pwd(66), 16'h0000);
    rd(`MCR_OFS_NPWD, 16'h0000);
    wr(`MCR_OFS_XRST, `MCR_PWD_RST, 16'h0000);
    wr(`MCR_OFS_XRST, u_mst.pwd(66), P_XR);
    wr(`MCR_OFS_FWUP, `MCR_PWD_RST, 16'h0000);
    rd(`MCR_OFS_FWUP, 16'h0000);
    wr(`MCR_OFS_FWUP, u_mst.pwd(66), P_FW);
    rd(`MCR_OFS_FWUP, 16'h0042);
    $display("test password done");
  endtask

  task automatic t_button();
    int n;
    @(posedge clk);
    button_update <= 1'b1;
    n = 0;
    // synchroniser plus edge detect needs a few cycles, bounded here
    while (update_mode !== 1'b1 && n < 10) begin
      idle(1);
      n++;
    end
    chk("update_mode", 16'h0001, {15'h0000, update_mode});
    rd(`MCR_OFS_STAT, 16'h000A);
    @(posedge clk);
    button_update <= 1'b0;
    wr(`MCR_OFS_TERM, 16'h0000, P_SR);
    idle(1);
    chk("update_mode", 16'h0000, {15'h0000, update_mode});
    $display("test button done");
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    compares = 0;
    rst = 1'b1;
    button_update = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_after_reset();
    t_reset_cmds();
    t_settings();
    t_checksum_write();
    t_password();
    t_button();
    give_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
